// ### sim/test_vsl_host_ctrl.sv
`timescale 1ns/1ps
module test_vsl_host_ctrl
	import vsl_pkg::*;
;
	localparam logic [DATA_W-1:0] LOCK_W = 16'h0001;
	localparam logic [DATA_W-1:0] ST_INI = 16'h00B0;
	localparam logic [DATA_W-1:0] ST_CLR = 16'h0080;
	localparam logic [17:0]       OK     = 18'h00000;
	localparam logic [17:0]       ERR    = 18'h20000;
	logic              i_sys_clk = 1'b0;
	logic              i_rst     = 1'b1;
	logic              req_valid = 1'b0;
	logic              susp      = 1'b0;
	vsl_req_t          req       = '0;
	logic              req_ready, rsp_valid, rsp_err, ce_n, oe_n, we_n, dq_oe;
	logic [DATA_W-1:0] rsp_data, dq_out, dev_dq, dq_bus;
	logic [ADDR_W-1:0] addr;
	vsl_state_t        st, dev_st;
	logic [1023:0]     lock;
	logic [15:0]       wr_cnt;
	logic [17:0]       exp_q[$];
	logic [17:0]       note;
	int                n_mismatch  = 0;
	int                comparisons = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	assign dq_bus = dq_oe ? dq_out : dev_dq;
	vsl_host_ctrl u_vsl_host_ctrl (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(req_valid), .i_req(req),
		.i_erase_suspended(susp), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
		.o_rsp_err(rsp_err), .o_state(st), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr),
		.o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq_in(dq_bus));
	vsl_flash_model u_vsl_flash_model (.i_sys_clk(i_sys_clk), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_addr(addr), .i_dq(dq_bus), .o_dq(dev_dq), .o_state(dev_st), .o_lock(lock), .o_wr_cnt(wr_cnt));
	// ----------------
	// Checking
	// ----------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	always @(posedge i_sys_clk) begin
		if (rsp_valid === 1'b1 && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			check(32'(rsp_err), 32'(note[17]));
			if (note[16]) check(32'(rsp_data), 32'(note[15:0]));
		end else if (rsp_valid === 1'b1) begin
			// A response nobody asked for
			check(32'(rsp_valid), 32'h0);
		end
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	// Note is {refused, data checked, data}; state is checked on both sides afterwards
	task automatic do_op(input vsl_op_t op, input logic [ADDR_W-1:0] sa, input logic [17:0] nt, input vsl_state_t ns);
		int n;
		exp_q.push_back(nt);
		req_valid <= 1'b1;
		req <= '{op: op, sector_addr: sa};
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		if (req_ready !== 1'b1) n_mismatch++;
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 200);
		if (rsp_valid !== 1'b1) n_mismatch++;
		@(posedge i_sys_clk);
		check(32'(st), 32'(ns));
		check(32'(dev_st), 32'(ns));
	endtask : do_op
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		logic [ADDR_W-1:0] sa;
		logic [15:0]       w0;
		void'($urandom(32'h6C2E4388));
		repeat (16) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		@(posedge i_sys_clk);
		w0 = wr_cnt;
		for (int k = 1; k < 7; k++) do_op(vsl_op_t'(k), '0, ERR, VSL_ST_READ);
		check(32'(wr_cnt), 32'(w0));
		$display("test refusals done");
		do_op(VSL_OP_ENTER, '0, OK, VSL_ST_OVERLAY);
		do_op(VSL_OP_ENTER, '0, ERR, VSL_ST_OVERLAY);
		repeat (4) begin
			sa = ADDR_W'($urandom);
			do_op(VSL_OP_SET_LOCK, sa, OK, VSL_ST_OVERLAY);
			check(32'(lock[sa[25:16]]), 32'h1);
			do_op(VSL_OP_READ_LOCK, sa, {2'b01, LOCK_W}, VSL_ST_OVERLAY);
			do_op(VSL_OP_CLR_LOCK, sa, OK, VSL_ST_OVERLAY);
			do_op(VSL_OP_READ_LOCK, sa, 18'h10000, VSL_ST_OVERLAY);
		end
		$display("test lock bits done");
		do_op(VSL_OP_READ_STAT, '0, {2'b01, ST_INI}, VSL_ST_OVERLAY);
		do_op(VSL_OP_CLR_STAT, '0, OK, VSL_ST_OVERLAY);
		do_op(VSL_OP_READ_STAT, '0, {2'b01, ST_CLR}, VSL_ST_OVERLAY);
		do_op(VSL_OP_EXIT, '0, OK, VSL_ST_READ);
		$display("test status and exit done");
		susp <= 1'b1;
		sa = ADDR_W'($urandom);
		do_op(VSL_OP_ENTER, '0, OK, VSL_ST_OVERLAY);
		do_op(VSL_OP_SET_LOCK, sa, OK, VSL_ST_OVERLAY);
		do_op(VSL_OP_READ_LOCK, sa, {2'b01, LOCK_W}, VSL_ST_OVERLAY);
		do_op(VSL_OP_ABORT, '0, OK, VSL_ST_READ);
		do_op(VSL_OP_READ_LOCK, sa, ERR, VSL_ST_READ);
		$display("test suspended overlay done");
		check(32'(exp_q.size()), 32'h0);
		test_done;
	end
	// 33 ops of under 40 cycles each; the span leaves a wide margin
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		n_mismatch++;
		test_done;
	end
endmodule : test_vsl_host_ctrl

// ### sim/vsl_flash_model.sv
`timescale 1ns/1ps
module vsl_flash_model
	import vsl_pkg::*;
#(
	parameter logic [DATA_W-1:0] LOCK_WORD  = 16'h0001,
	parameter logic [DATA_W-1:0] STAT_INIT  = 16'h00B0,
	parameter logic [DATA_W-1:0] STAT_CLR   = 16'h0080,
	parameter logic [7:0]        ENTER_CODE = 8'hE0
) (
	// Pins, sampled on the host clock
	input  wire logic              i_sys_clk,
	input  wire logic              i_ce_n,
	input  wire logic              i_oe_n,
	input  wire logic              i_we_n,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_dq,
	output logic [DATA_W-1:0]      o_dq,
	// Observation
	output vsl_state_t             o_state = VSL_ST_READ,
	output logic [1023:0]          o_lock = '0,
	output logic [15:0]            o_wr_cnt = '0
);
	// ----------------
	// Read side
	// ----------------
	logic              ce_q = 1'b1;
	logic              oe_q = 1'b1;
	logic              we_q = 1'b1;
	logic [ADDR_W-1:0] a_q;
	logic [7:0]        d_q;
	logic [DATA_W-1:0] stat = STAT_INIT;
	logic [DATA_W-1:0] rd_val;
	logic [DATA_W-1:0] rd_last = '0;
	logic              unl;
	always_comb begin
		if (o_state == VSL_ST_STAT_RD) rd_val = stat;
		else if (o_state == VSL_ST_OVERLAY) rd_val = o_lock[i_addr[25:16]] ? LOCK_WORD : '0;
		else rd_val = 16'hFFFF;
	end
	// Released bus must not look like a held word
	assign o_dq = (!i_ce_n && !i_oe_n) ? rd_val : ~rd_last;
	assign unl = a_q[11:0] == ADDR_UNLOCK;
	// ----------------
	// Command side
	// ----------------
	always @(posedge i_sys_clk) begin
		ce_q <= i_ce_n;
		oe_q <= i_oe_n;
		we_q <= i_we_n;
		a_q <= i_addr;
		d_q <= i_dq[7:0];
		if (!ce_q && !oe_q && i_oe_n) begin
			rd_last <= rd_val;
			if (o_state == VSL_ST_STAT_RD) o_state <= VSL_ST_OVERLAY;
		end
		if (!ce_q && !we_q && i_we_n) begin
			o_wr_cnt <= o_wr_cnt + 16'h0001;
			// suspended overlay shares this table; other codes do nothing
			case (o_state)
				VSL_ST_READ: if (unl && d_q == ENTER_CODE) o_state <= VSL_ST_OVERLAY;
				VSL_ST_OVERLAY: begin
					if (d_q == CMD_RESET) o_state <= VSL_ST_READ;
					else if (unl && d_q == CMD_SR_READ) o_state <= VSL_ST_STAT_RD;
					else if (unl && d_q == CMD_SR_CLEAR) stat <= STAT_CLR;
					else if (d_q == CMD_EXIT_ENTRY) o_state <= VSL_ST_EXIT_PEND;
					else if (d_q == CMD_SET_ENTRY) o_state <= VSL_ST_SET_CLEAR;
				end
				VSL_ST_SET_CLEAR: if (d_q == CMD_LOCK_SET || d_q == CMD_LOCK_CLEAR) begin
					o_lock[a_q[25:16]] <= d_q == CMD_LOCK_SET;
					o_state <= VSL_ST_OVERLAY;
				end
				VSL_ST_EXIT_PEND: if (d_q == CMD_EXIT) o_state <= VSL_ST_READ;
				default: ;
			endcase
		end
	end
endmodule : vsl_flash_model

// ### src/vsl_bus_cycle.sv
`timescale 1ns/1ps
module vsl_bus_cycle
	import vsl_pkg::*;
#(
	parameter int STROBE = STROBE_CYCLES,
	parameter int RECOVER = RECOVER_CYCLES
) (
	// Clock and reset
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst,
	// Cycle request
	input  wire logic                i_start,
	input  wire vsl_cyc_t            i_cyc,
	output logic                     o_ready,
	output logic                     o_done,
	output logic [DATA_W-1:0]        o_rdata,
	// Flash pins
	output logic                     o_ce_n,
	output logic                     o_oe_n,
	output logic                     o_we_n,
	output logic [ADDR_W-1:0]        o_addr,
	output logic [DATA_W-1:0]        o_dq_out,
	output logic                     o_dq_oe,
	input  wire logic [DATA_W-1:0]   i_dq_in
);

	// ----------------------------------------------------------------
	// One asynchronous cycle: strobe low for STROBE, then recovery
	// ----------------------------------------------------------------
	logic [7:0]        cnt_reg, cnt_next;
	typedef enum logic [1:0] {
		VSL_PH_IDLE    = 2'h0,
		VSL_PH_STROBE  = 2'h1,
		VSL_PH_RECOVER = 2'h2
	} vsl_phase_t;

	vsl_phase_t        ph_reg, ph_next;
	vsl_cyc_t          cyc_reg, cyc_next;
	logic [DATA_W-1:0] rd_reg, rd_next;
	logic              done_reg, done_next;

	always_comb begin
		cnt_next  = cnt_reg;
		ph_next   = ph_reg;
		cyc_next  = cyc_reg;
		rd_next   = rd_reg;
		done_next = 1'b0;
		unique case (ph_reg)
			VSL_PH_IDLE: begin
				if (i_start) begin
					cyc_next = i_cyc;
					cnt_next = 8'(STROBE - 1);
					ph_next  = VSL_PH_STROBE;
				end
			end
			VSL_PH_STROBE: begin
				if (cnt_reg == 8'h00) begin
					// Data latched at end of strobe, before OE# rises
					if (!cyc_reg.we)
						rd_next = i_dq_in;
					cnt_next = 8'(RECOVER - 1);
					ph_next  = VSL_PH_RECOVER;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			VSL_PH_RECOVER: begin
				if (cnt_reg == 8'h00) begin
					done_next = 1'b1;
					ph_next   = VSL_PH_IDLE;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			default: ph_next = VSL_PH_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_reg  <= 8'h00;
			ph_reg   <= VSL_PH_IDLE;
			cyc_reg  <= '0;
			rd_reg   <= '0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			ph_reg   <= ph_next;
			cyc_reg  <= cyc_next;
			rd_reg   <= rd_next;
			done_reg <= done_next;
		end
	end

	assign o_ready  = (ph_reg == VSL_PH_IDLE);
	assign o_done   = done_reg;
	assign o_rdata  = rd_reg;
	assign o_ce_n   = (ph_reg != VSL_PH_STROBE);
	assign o_we_n   = !((ph_reg == VSL_PH_STROBE) && cyc_reg.we);
	assign o_oe_n   = !((ph_reg == VSL_PH_STROBE) && !cyc_reg.we);
	assign o_addr   = cyc_reg.addr;
	assign o_dq_out = cyc_reg.data;
	assign o_dq_oe  = cyc_reg.we && (ph_reg != VSL_PH_IDLE);

endmodule : vsl_bus_cycle

// ### src/vsl_host_ctrl.sv
`timescale 1ns/1ps
module vsl_host_ctrl
	import vsl_pkg::*;
#(
	parameter int STROBE  = STROBE_CYCLES,
	parameter int RECOVER = RECOVER_CYCLES
) (
	// Clock and reset
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst,
	// Command port
	input  wire logic                i_req_valid,
	input  wire vsl_req_t            i_req,
	input  wire logic                i_erase_suspended,
	output logic                     o_req_ready,
	output logic                     o_rsp_valid,
	output logic [DATA_W-1:0]        o_rsp_data,
	output logic                     o_rsp_err,
	output vsl_state_t               o_state,
	// Flash pins
	output logic                     o_ce_n,
	output logic                     o_oe_n,
	output logic                     o_we_n,
	output logic [ADDR_W-1:0]        o_addr,
	output logic [DATA_W-1:0]        o_dq_out,
	output logic                     o_dq_oe,
	input  wire logic [DATA_W-1:0]   i_dq_in
);

	// ----------------------------------------------------------------
	// Sequencer: each op is a short list of bus cycles
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		VSL_SQ_IDLE  = 2'h0,
		VSL_SQ_ISSUE = 2'h1,
		VSL_SQ_WAIT  = 2'h2,
		VSL_SQ_RESP  = 2'h3
	} vsl_seq_t;

	vsl_seq_t          sq_reg, sq_next;
	vsl_state_t        st_reg, st_next;
	vsl_req_t          req_reg, req_next;
	logic [1:0]        step_reg, step_next;
	logic              err_reg, err_next;
	logic              susp_reg, susp_next;
	logic [DATA_W-1:0] data_reg, data_next;

	logic              bc_start;
	logic              bc_ready;
	logic              bc_done;
	logic [DATA_W-1:0] bc_rdata;
	vsl_cyc_t          cyc;
	logic              last;
	logic              legal;

	// Legality of an op against the overlay state the host tracks
	always_comb begin
		unique case (i_req.op)
			VSL_OP_ENTER:     legal = (st_reg == VSL_ST_READ);
			VSL_OP_ABORT:     legal = 1'b1;
			default:          legal = (st_reg == VSL_ST_OVERLAY);
		endcase
	end

	// Cycle for the current step, and whether it is the last one
	always_comb begin
		cyc  = '0;
		last = 1'b1;
		unique case (req_reg.op)
			VSL_OP_ENTER: begin
				// Entry sequence is not part of the overlay table, kept to a plain unlock
				cyc.we = 1'b1;
				cyc.addr = ADDR_W'(ADDR_UNLOCK);
				cyc.data = DATA_W'(CMD_ENTER);
			end
			VSL_OP_READ_LOCK: begin
				cyc.addr = req_reg.sector_addr;
			end
			VSL_OP_READ_STAT: begin
				last = (step_reg == 2'h1);
				cyc.we = (step_reg == 2'h0);
				cyc.addr = ADDR_W'(ADDR_UNLOCK);
				cyc.data = DATA_W'(CMD_SR_READ);
			end
			VSL_OP_CLR_STAT: begin
				cyc.we = 1'b1;
				cyc.addr = ADDR_W'(ADDR_UNLOCK);
				cyc.data = DATA_W'(CMD_SR_CLEAR);
			end
			VSL_OP_SET_LOCK, VSL_OP_CLR_LOCK: begin
				// set/clear entry, then code at sector
				last = (step_reg == 2'h1);
				cyc.we = 1'b1;
				cyc.addr = (step_reg == 2'h0) ? '0 : req_reg.sector_addr;
				cyc.data = (step_reg == 2'h0) ? DATA_W'(CMD_SET_ENTRY) :
					(req_reg.op == VSL_OP_SET_LOCK) ? DATA_W'(CMD_LOCK_SET) : DATA_W'(CMD_LOCK_CLEAR);
			end
			VSL_OP_EXIT: begin
				last = (step_reg == 2'h1);
				cyc.we = 1'b1;
				cyc.data = (step_reg == 2'h0) ? DATA_W'(CMD_EXIT_ENTRY) : DATA_W'(CMD_EXIT);
			end
			VSL_OP_ABORT: begin
				cyc.we = 1'b1;
				cyc.data = DATA_W'(CMD_RESET);
			end
			default: cyc = '0;
		endcase
	end

	// Overlay state after each completed cycle
	always_comb begin
		st_next = st_reg;
		if (bc_done) begin
			unique case (st_reg)
				VSL_ST_READ:
					if (req_reg.op == VSL_OP_ENTER)
						st_next = VSL_ST_OVERLAY;
				VSL_ST_OVERLAY: begin
					if (cyc.we && cyc.data == DATA_W'(CMD_RESET))
						st_next = VSL_ST_READ;
					else if (cyc.we && cyc.data == DATA_W'(CMD_SR_READ))
						st_next = VSL_ST_STAT_RD;
					else if (cyc.we && cyc.data == DATA_W'(CMD_SET_ENTRY))
						st_next = VSL_ST_SET_CLEAR;
					else if (cyc.we && cyc.data == DATA_W'(CMD_EXIT_ENTRY))
						st_next = VSL_ST_EXIT_PEND;
				end
				VSL_ST_STAT_RD:   st_next = VSL_ST_OVERLAY;
				// back to overlay after set or clear
				VSL_ST_SET_CLEAR: if (cyc.we) st_next = VSL_ST_OVERLAY;
				VSL_ST_EXIT_PEND: if (cyc.we && cyc.data == DATA_W'(CMD_EXIT)) st_next = VSL_ST_READ;
				default:          st_next = VSL_ST_READ;
			endcase
			if (req_reg.op == VSL_OP_ABORT)
				st_next = VSL_ST_READ;
		end
	end

	// Request sequencing
	always_comb begin
		sq_next   = sq_reg;
		req_next  = req_reg;
		step_next = step_reg;
		err_next  = err_reg;
		susp_next = susp_reg;
		data_next = data_reg;
		bc_start  = 1'b0;
		unique case (sq_reg)
			VSL_SQ_IDLE: begin
				if (i_req_valid) begin
					req_next  = i_req;
					step_next = 2'h0;
					data_next = '0;
					// illegal ops never reach the pins
					err_next  = !legal;
					sq_next   = legal ? VSL_SQ_ISSUE : VSL_SQ_RESP;
					// suspended variant uses the same codes
					if (i_req.op == VSL_OP_ENTER)
						susp_next = i_erase_suspended;
				end
			end
			VSL_SQ_ISSUE: begin
				if (bc_ready) begin
					bc_start = 1'b1;
					sq_next  = VSL_SQ_WAIT;
				end
			end
			VSL_SQ_WAIT: begin
				if (bc_done) begin
					// lock word or status word returned
					if (!cyc.we)
						data_next = bc_rdata;
					step_next = step_reg + 2'h1;
					sq_next   = last ? VSL_SQ_RESP : VSL_SQ_ISSUE;
				end
			end
			VSL_SQ_RESP: sq_next = VSL_SQ_IDLE;
			default:     sq_next = VSL_SQ_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sq_reg   <= VSL_SQ_IDLE;
			st_reg   <= VSL_ST_READ;
			req_reg  <= '0;
			step_reg <= 2'h0;
			err_reg  <= 1'b0;
			susp_reg <= 1'b0;
			data_reg <= '0;
		end else begin
			sq_reg   <= sq_next;
			st_reg   <= st_next;
			req_reg  <= req_next;
			step_reg <= step_next;
			err_reg  <= err_next;
			susp_reg <= susp_next;
			data_reg <= data_next;
		end
	end

	assign o_req_ready = (sq_reg == VSL_SQ_IDLE);
	assign o_rsp_valid = (sq_reg == VSL_SQ_RESP);
	assign o_rsp_data  = data_reg;
	assign o_rsp_err   = err_reg;
	assign o_state     = st_reg;

	vsl_bus_cycle #(
		.STROBE  (STROBE),
		.RECOVER (RECOVER)
	) u_cycle (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_start   (bc_start),
		.i_cyc     (cyc),
		.o_ready   (bc_ready),
		.o_done    (bc_done),
		.o_rdata   (bc_rdata),
		.o_ce_n    (o_ce_n),
		.o_oe_n    (o_oe_n),
		.o_we_n    (o_we_n),
		.o_addr    (o_addr),
		.o_dq_out  (o_dq_out),
		.o_dq_oe   (o_dq_oe),
		.i_dq_in   (i_dq_in)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_abort_to_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		bc_done && cyc.we && cyc.data == DATA_W'(CMD_RESET) |=> st_reg == VSL_ST_READ)
		else $error("reset code did not return to array read");
	a_stat_read_back: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		bc_done && st_reg == VSL_ST_STAT_RD |=> st_reg == VSL_ST_OVERLAY)
		else $error("status read did not return to overlay");
	a_exit_pend_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		st_reg == VSL_ST_EXIT_PEND && !(bc_done && cyc.we) |=> st_reg == VSL_ST_EXIT_PEND)
		else $error("exit-pending left without a write");
	a_set_back: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		bc_done && st_reg == VSL_ST_SET_CLEAR && cyc.we |=> st_reg == VSL_ST_OVERLAY)
		else $error("set/clear did not return to overlay");
	a_illegal_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		sq_reg == VSL_SQ_IDLE && i_req_valid && !legal |=> sq_reg == VSL_SQ_RESP && o_rsp_err && o_ce_n)
		else $error("illegal op reached the bus");
	a_strobe_width: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$fell(o_ce_n) |-> !o_ce_n [*6])
		else $error("strobe shorter than minimum");
	c_lock_set: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		o_rsp_valid && req_reg.op == VSL_OP_SET_LOCK && !o_rsp_err);
	c_stat_read: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		o_rsp_valid && req_reg.op == VSL_OP_READ_STAT);
	c_exit: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		o_rsp_valid && req_reg.op == VSL_OP_EXIT && o_state == VSL_ST_READ);
	c_suspended_set: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		o_rsp_valid && susp_reg && req_reg.op == VSL_OP_SET_LOCK);

endmodule : vsl_host_ctrl

// ### src/vsl_pkg.sv
package vsl_pkg;

	// ----------------------------------------------------------------
	// Bus widths and command codes
	// ----------------------------------------------------------------
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;

	localparam logic [7:0]  CMD_RESET       = 8'hF0;
	localparam logic [7:0]  CMD_SR_READ     = 8'h70;
	localparam logic [7:0]  CMD_SR_CLEAR    = 8'h71;
	localparam logic [7:0]  CMD_EXIT_ENTRY  = 8'h90;
	localparam logic [7:0]  CMD_EXIT        = 8'h00;
	localparam logic [7:0]  CMD_SET_ENTRY   = 8'hA0;
	localparam logic [7:0]  CMD_LOCK_SET    = 8'h00;
	localparam logic [7:0]  CMD_LOCK_CLEAR  = 8'h01;
	localparam logic [11:0] ADDR_UNLOCK     = 12'h555;
	// Overlay entry code is a local choice, the entry sequence is outside this block
	localparam logic [7:0]  CMD_ENTER       = 8'hE0;

	// ----------------------------------------------------------------
	// Bus cycle timing (cycles of the 100 MHz clock)
	// ----------------------------------------------------------------
	localparam int CLK_NS        = 10;
	localparam int STROBE_NS     = 60;
	localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOVER_NS    = 30;
	localparam int RECOVER_CYCLES = (RECOVER_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// Host operations and overlay states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		VSL_OP_ENTER     = 3'h0,
		VSL_OP_READ_LOCK = 3'h1,
		VSL_OP_READ_STAT = 3'h2,
		VSL_OP_CLR_STAT  = 3'h3,
		VSL_OP_SET_LOCK  = 3'h4,
		VSL_OP_CLR_LOCK  = 3'h5,
		VSL_OP_EXIT      = 3'h6,
		VSL_OP_ABORT     = 3'h7
	} vsl_op_t;

	typedef enum logic [2:0] {
		VSL_ST_READ      = 3'h0,
		VSL_ST_OVERLAY   = 3'h1,
		VSL_ST_STAT_RD   = 3'h2,
		VSL_ST_SET_CLEAR = 3'h3,
		VSL_ST_EXIT_PEND = 3'h4
	} vsl_state_t;

	typedef struct packed {
		vsl_op_t             op;
		logic [ADDR_W-1:0]   sector_addr;
	} vsl_req_t;

	typedef struct packed {
		logic                we;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
	} vsl_cyc_t;

endpackage : vsl_pkg
